// [bench/flash_program_erase_suspend_test.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_suspend_test;
  import fps_pkg::*;
  localparam int PC = 300;
  localparam int SC = 400;
  localparam logic [63:0] QP = {OP_QUAD_PROGRAM, 24'h0000FE, 32'h11223344};
  logic refClk = 1'b0;
  logic rst = 1'b1;
  logic quad = 1'b0;
  logic pfd = 1'b0;
  logic [3:0] prot = 4'h0;
  logic wRdy = 1'b0;
  logic linkClk, csN, write_in_progress_flag, write_enable_latch, esf, psf, wEn;
  logic [3:0] io;
  logic [2:0] op;
  logic [23:0] tgt, wAddr;
  logic [7:0] wData;
  logic [7:0] mem [logic [23:0]];
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  int busyCnt = 0;
  int nW = 0;
  always #2 refClk = ~refClk;
  fps_host_model u_host (.refClk(refClk), .linkClk(linkClk), .chipSelectN(csN), .ioLine(io));
  fps_flash_seq #(.PROG_CYC(PC), .SECT_CYC(SC), .HALF_CYC(500), .BLK_CYC(600), .CHIP_CYC(700),
    .SUSP_CYC(20)) uut (.ref_clk(refClk), .rst(rst), .linkClk(linkClk), .chipSelectN(csN),
    .ioLineIn(io), .quadPeripheral(quad), .pinFunctionDisableBit(pfd), .protectBits(prot),
    .writeInProgressFlag(write_in_progress_flag), .writeEnableLatch(write_enable_latch), .eraseSuspendedFlag(esf),
    .programSuspendedFlag(psf), .activeOp(op), .targetAddr(tgt), .progWrEn(wEn),
    .progWrAddr(wAddr), .progWrData(wData), .progWrReady(wRdy));
  // Array side stalls every other cycle
  always @(posedge refClk) begin
    if (wEn === 1'b1 && wRdy === 1'b1) begin
      mem[wAddr] = wData;
      nW++;
    end
    if (write_in_progress_flag === 1'b1 && esf === 1'b0 && psf === 1'b0) busyCnt++;
    #1 wRdy = ~wRdy;
  end
  always @(posedge refClk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [63:0] v, input int n, input int q);
    u_host.frame(v, n, q);
    repeat (4) @(posedge refClk);
    #1;
  endtask
  task automatic op1(input logic [7:0] o);
    cmd({o, 56'h0}, quad ? 2 : 8, quad ? 0 : 8);
  endtask
  task automatic erase(input logic [7:0] o, input logic [23:0] a);
    op1(OP_WRITE_ENABLE);
    cmd({o, a, 32'h0}, 32, 32);
  endtask
  task automatic waitIdle(input int lim);
    int i;
    i = 0;
    while (write_in_progress_flag !== 1'b0 && i < lim) begin
      @(posedge refClk);
      #1;
      i++;
    end
    check(write_in_progress_flag, 1'h0);
  endtask
  initial begin
    repeat (8) @(posedge refClk);
    #1 rst = 1'b0;
    repeat (4) @(posedge refClk);
    #1;
    check({write_in_progress_flag, write_enable_latch, esf, psf, op}, 7'h00);
    cmd(QP, 22, 8);
    check(write_in_progress_flag, 1'h0);
    op1(OP_WRITE_ENABLE);
    check(write_enable_latch, 1'h1);
    cmd(QP, 22, 8);
    check(write_in_progress_flag, 1'h0);
    pfd = 1'b1;
    cmd(QP, 22, 8);
    check({write_in_progress_flag, op}, {1'h1, FPS_OP_PROGRAM});
    waitIdle(PC + 600);
    check(write_enable_latch, 1'h0);
    check(nW, 4'h4);
    check({mem[24'h0000FE], mem[24'h0000FF]}, 16'h1122);
    check({mem[24'h000000], mem[24'h000001]}, 16'h3344);
    busyCnt = 0;
    erase(OP_SECTOR_ERASE, 24'h012345);
    check({write_in_progress_flag, op, tgt}, {1'h1, FPS_OP_SECTOR, 24'h012345});
    quad = 1'b1;
    op1(OP_SUSPEND);
    check({esf, psf}, 2'h2);
    waitIdle(200);
    op1(OP_SUSPEND);
    check({esf, psf, op}, {2'h2, FPS_OP_SECTOR});
    op1(OP_WRITE_ENABLE);
    op1(OP_CHIP_ERASE_A);
    check({write_in_progress_flag, op}, {1'h0, FPS_OP_SECTOR});
    op1(OP_RESUME);
    check({esf, write_in_progress_flag}, 2'h1);
    waitIdle(SC + 100);
    check(busyCnt <= SC + 8, 1'h1);
    op1(OP_RESUME);
    check({write_in_progress_flag, esf, psf}, 3'h0);
    quad = 1'b0;
    op1(OP_WRITE_ENABLE);
    cmd({OP_SECTOR_ERASE, 16'h0100, 40'h0}, 24, 24);
    check(write_in_progress_flag, 1'h0);
    prot = 4'h1;
    erase(OP_SECTOR_ERASE, 24'h03F000);
    check(write_in_progress_flag, 1'h0);
    erase(OP_HALF_BLOCK_ERASE, 24'h038000);
    check(write_in_progress_flag, 1'h0);
    erase(OP_HALF_BLOCK_ERASE, 24'h008000);
    check({write_in_progress_flag, op}, {1'h1, FPS_OP_HALF});
    waitIdle(700);
    check(write_enable_latch, 1'h0);
    prot = 4'h0;
    op1(OP_WRITE_ENABLE);
    cmd(QP, 22, 8);
    // Suspend only lands in the timed cycle, after the page flush
    repeat (300) @(posedge refClk);
    #1;
    op1(OP_SUSPEND);
    check({esf, psf, op}, {2'h1, FPS_OP_PROGRAM});
    waitIdle(200);
    op1(OP_RESUME);
    check(psf, 1'h0);
    waitIdle(PC + 600);
    op1(OP_WRITE_ENABLE);
    op1(OP_CHIP_ERASE_A);
    check(op, FPS_OP_CHIP);
    op1(OP_SUSPEND);
    check({esf, psf, write_in_progress_flag}, 3'h1);
    waitIdle(900);
    test_done();
  end
endmodule // flash_program_erase_suspend_test
`default_nettype wire

// [bench/fps_flash_seq_props.sv]
`timescale 1ns/1ps
`default_nettype none
module fps_flash_seq_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic writeInProgressFlag,
  input wire logic writeEnableLatch,
  input wire logic eraseSuspendedFlag,
  input wire logic programSuspendedFlag,
  input wire logic [2:0] activeOp,
  input wire logic [23:0] targetAddr,
  input wire logic progWrEn,
  input wire logic [23:0] progWrAddr,
  input wire logic [7:0] progWrData,
  input wire logic progWrReady
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic susp;
  assign susp = eraseSuspendedFlag || programSuspendedFlag;
  // Resume also raises busy, so look back two cycles for a suspension
  a_start_needs_wel: assert property ($rose(writeInProgressFlag) && !$past(susp) && !$past(susp, 2)
    |-> $past(writeEnableLatch)) else $error("cycle started without write enable latch");
  a_wel_at_end: assert property ($fell(writeInProgressFlag) && !susp |-> !writeEnableLatch)
    else $error("write enable latch still set after cycle");
  a_one_suspended: assert property (!(eraseSuspendedFlag && programSuspendedFlag))
    else $error("two operations suspended");
  a_erase_susp_op: assert property (eraseSuspendedFlag |-> activeOp inside {3'h2, 3'h3, 3'h4})
    else $error("erase suspend flag without erase");
  a_prog_susp_op: assert property (programSuspendedFlag |-> activeOp == 3'h1)
    else $error("program suspend flag without program");
  a_chip_no_susp: assert property (activeOp == 3'h5 |-> !susp)
    else $error("chip erase suspended");
  a_wr_hold: assert property (progWrEn && !progWrReady |=> progWrEn && $stable(progWrAddr)
    && $stable(progWrData)) else $error("array write dropped before ready");
  a_wr_in_page: assert property (progWrEn |-> progWrAddr[23:8] == targetAddr[23:8])
    else $error("array write left the page");
  a_resume_busy: assert property ($fell(susp) |-> ##[0:2] writeInProgressFlag)
    else $error("resume did not restart the cycle");
  c_erase_susp: cover property ($rose(eraseSuspendedFlag));
  c_prog_susp: cover property ($rose(programSuspendedFlag));
  c_chip: cover property (activeOp == 3'h5);
endmodule // fps_flash_seq_props
bind fps_flash_seq fps_flash_seq_props u_props (.ref_clk(ref_clk), .rst(rst),
  .writeInProgressFlag(writeInProgressFlag), .writeEnableLatch(writeEnableLatch),
  .eraseSuspendedFlag(eraseSuspendedFlag), .programSuspendedFlag(programSuspendedFlag),
  .activeOp(activeOp), .targetAddr(targetAddr), .progWrEn(progWrEn), .progWrAddr(progWrAddr),
  .progWrData(progWrData), .progWrReady(progWrReady));
`default_nettype wire

// [bench/fps_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fps_host_model (
  input wire logic refClk,
  output logic linkClk,
  output logic chipSelectN,
  output logic [3:0] ioLine
);
  initial begin
    linkClk = 1'b0;
    chipSelectN = 1'b1;
    ioLine = 4'h5;
  end
  task automatic half();
    repeat (8) @(posedge refClk);
    #1;
  endtask
  // Sends n units MSB first; units from q on are nibbles
  task automatic frame(input logic [63:0] v, input int n, input int q);
    int k;
    k = 63;
    half();
    chipSelectN = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i < q) begin
        // Unused lines toggle so no stale level can pass for data
        ioLine = {~ioLine[3:1], v[k]};
        k = k - 1;
      end else begin
        ioLine = v[k-:4];
        k = k - 4;
      end
      half();
      linkClk = 1'b1;
      half();
      linkClk = 1'b0;
    end
    chipSelectN = 1'b1;
    ioLine = ~ioLine;
    half();
  endtask
endmodule // fps_host_model
`default_nettype wire

// [rtl/fps_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module fps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;
  wire logic doWrite = inValid && inReady;
  wire logic doRead = outValid && outReady;
  wire logic [AW:0] count = wrPtr - rdPtr;
  assign inReady = count != DEPTH[AW:0];
  assign outValid = count != '0;
  assign outData = mem[rdPtr[AW-1:0]];
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (doWrite) wrPtr <= wrPtr + 1'b1;
      if (doRead) rdPtr <= rdPtr + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (doWrite) mem[wrPtr[AW-1:0]] <= inData;
  end
endmodule // fps_fifo
`default_nettype wire

// [rtl/fps_flash_seq.sv]
`timescale 1ns/1ps
`default_nettype none
module fps_flash_seq
  import fps_pkg::*;
#(
  parameter int PROG_CYC = fps_pkg::PROGRAM_CYCLES,
  parameter int SECT_CYC = fps_pkg::SECTOR_ERASE_CYCLES,
  parameter int HALF_CYC = fps_pkg::HALF_BLOCK_ERASE_CYCLES,
  parameter int BLK_CYC = fps_pkg::BLOCK_ERASE_CYCLES,
  parameter int CHIP_CYC = fps_pkg::CHIP_ERASE_CYCLES,
  parameter int SUSP_CYC = fps_pkg::SUSPEND_LATENCY_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic chipSelectN,
  input wire logic [3:0] ioLineIn,
  input wire logic quadPeripheral,
  input wire logic pinFunctionDisableBit,
  input wire logic [3:0] protectBits,
  output logic writeInProgressFlag,
  output logic writeEnableLatch,
  output logic eraseSuspendedFlag,
  output logic programSuspendedFlag,
  output logic [2:0] activeOp,
  output logic [23:0] targetAddr,
  output logic progWrEn,
  output logic [23:0] progWrAddr,
  output logic [7:0] progWrData,
  input wire logic progWrReady
);
  import fps_pkg::*;
  initial begin
    if (PROG_CYC < 1 || SECT_CYC < 1 || HALF_CYC < 1 || BLK_CYC < 1 || CHIP_CYC < 1 || SUSP_CYC < 1)
      $error("cycle counts must be positive");
  end
  typedef enum logic [1:0] {
    FPS_IDLE = 2'b00,
    FPS_BUSY = 2'b01,
    FPS_SUSP_WAIT = 2'b10,
    FPS_FLUSH = 2'b11
  } fps_state_e;
  // Two-stage synchronisers; only stage two is read
  logic [1:0] clkSync, csSync;
  logic [3:0] ioSync0, ioSync1;
  logic clkPrev;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clkSync <= 2'b00;
      csSync <= 2'b11;
      ioSync0 <= 4'h0;
      ioSync1 <= 4'h0;
      clkPrev <= 1'b0;
    end else begin
      clkSync <= {clkSync[0], linkClk};
      csSync <= {csSync[0], chipSelectN};
      ioSync0 <= ioLineIn;
      ioSync1 <= ioSync0;
      clkPrev <= clkSync[1];
    end
  end
  wire logic csLow = !csSync[1];
  wire logic sclkRise = clkSync[1] && !clkPrev && csLow;
  logic csPrevLow;
  always_ff @(posedge ref_clk) begin
    if (rst) csPrevLow <= 1'b0;
    else csPrevLow <= csLow;
  end
  wire logic csRise = csPrevLow && !csLow;
  wire logic csFall = !csPrevLow && csLow;
  // Shifter: serial on io0 for opcode unless quad mode; quad for address and data of 32h
  logic [7:0] shiftReg;
  logic [3:0] bitCnt;
  logic [7:0] opcode;
  logic [2:0] byteCnt;
  logic [23:0] addrReg;
  logic [8:0] dataBytes;
  logic quadData;
  wire logic quadLanes = quadPeripheral || quadData;
  wire logic [3:0] stepBits = quadLanes ? 4'd4 : 4'd1;
  wire logic [7:0] nextShift = quadLanes ? {shiftReg[3:0], ioSync1} : {shiftReg[6:0], ioSync1[0]};
  wire logic byteDone = sclkRise && (bitCnt + stepBits == 4'd8);
  wire logic opcodeDone = byteDone && byteCnt == 3'd0;
  always_ff @(posedge ref_clk) begin
    if (rst || csFall) begin
      shiftReg <= 8'h00;
      bitCnt <= 4'd0;
      byteCnt <= 3'd0;
      opcode <= 8'h00;
      addrReg <= 24'h0;
      quadData <= 1'b0;
      dataBytes <= 9'd0;
    end else if (sclkRise) begin
      shiftReg <= nextShift;
      bitCnt <= byteDone ? 4'd0 : bitCnt + stepBits;
      if (byteDone) begin
        if (byteCnt < 3'd4) byteCnt <= byteCnt + 3'd1;
        if (byteCnt == 3'd0) begin
          opcode <= nextShift;
          quadData <= nextShift == OP_QUAD_PROGRAM;
        end
        if (byteCnt >= 3'd1 && byteCnt <= 3'd3) addrReg <= {addrReg[15:0], nextShift};
        if (byteCnt == 3'd4 && dataBytes != 9'd511) dataBytes <= dataBytes + 9'd1;
      end
    end
  end
  wire logic frameClean = bitCnt == 4'd0;
  wire logic isProgOp = opcode == OP_QUAD_PROGRAM || opcode == OP_PAGE_PROGRAM;
  wire logic dataByteStrobe = byteDone && byteCnt == 3'd4;
  // Data into page buffer through FIFO; wrap inside page
  logic [7:0] pageFill;
  logic capture;
  wire logic fifoInReady;
  wire logic fifoOutValid;
  wire logic [7:0] fifoOutData;
  fps_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
    .clk(ref_clk), .rst(rst),
    .inValid(dataByteStrobe && isProgOp && capture), .inReady(fifoInReady), .inData(nextShift),
    .outValid(fifoOutValid), .outReady(1'b1), .outData(fifoOutData)
  );
  logic [7:0] bufWrAddr;
  always_ff @(posedge ref_clk) begin
    if (rst || csFall) bufWrAddr <= 8'h00;
    else if (opcodeDone) bufWrAddr <= 8'h00;
    else if (byteDone && byteCnt == 3'd3) bufWrAddr <= nextShift;
    else if (fifoOutValid) bufWrAddr <= bufWrAddr + 8'h01;
  end
  logic [255:0] pageMask;
  logic [7:0] flushIdx;
  logic [7:0] bufRdData;
  fps_page_buf #(.DEPTH(PAGE_BYTES)) u_page (
    .clk(ref_clk), .write_enable_cmd(fifoOutValid), .wrAddr(bufWrAddr), .wrData(fifoOutData),
    .rdAddr(flushIdx), .rdData(bufRdData)
  );
  // Overflow drops bytes; a lost byte voids the command
  logic overrun;
  always_ff @(posedge ref_clk) begin
    if (rst || csFall) begin
      pageMask <= '0;
      overrun <= 1'b0;
      capture <= 1'b0;
    end else begin
      if (opcodeDone) capture <= 1'b1;
      if (dataByteStrobe && isProgOp && !fifoInReady) overrun <= 1'b1;
      if (fifoOutValid) pageMask[bufWrAddr] <= 1'b1;
    end
  end
  // Protection: top-down region of 32KB, doubling per protectBits step; 4 and up protects all
  function automatic logic isProtected(input logic [3:0] bp, input logic [23:0] a);
    logic [17:0] lim;
    lim = 18'd0;
    if (bp != 4'h0) lim = (bp >= 4'd8) ? 18'h00000 : 18'(18'h40000 - (18'h08000 << (bp - 4'd1)));
    if (bp == 4'h0) isProtected = 1'b0;
    else isProtected = a[17:0] >= lim;
  endfunction
  fps_state_e state;
  fps_op_e curOp;
  logic suspended;
  logic [31:0] remain;
  logic [31:0] waitCnt;
  logic flushRun;
  logic flushValid;
  // One byte in flight at a time, so a stalled array write is never overwritten
  wire logic flushStep = state == FPS_FLUSH && flushRun && !flushValid && !progWrEn;
  wire logic busyIdle = state == FPS_IDLE;
  wire logic addrCmdOk = csRise && byteCnt == 3'd4 && frameClean && dataBytes == 9'd0;
  wire logic progCmdOk = csRise && byteCnt == 3'd4 && frameClean && dataBytes != 9'd0 && !overrun;
  wire logic opOnlyOk = csRise && byteCnt == 3'd1 && frameClean;
  wire logic wrOk = writeEnableLatch && busyIdle && !suspended;
  wire logic goQuad = progCmdOk && opcode == OP_QUAD_PROGRAM && wrOk && pinFunctionDisableBit
                      && !isProtected(protectBits, addrReg);
  wire logic goProg = goQuad || (progCmdOk && opcode == OP_PAGE_PROGRAM && wrOk && !isProtected(protectBits, addrReg));
  wire logic goSect = addrCmdOk && opcode == OP_SECTOR_ERASE && wrOk && !isProtected(protectBits, addrReg);
  wire logic goHalf = addrCmdOk && opcode == OP_HALF_BLOCK_ERASE && wrOk && !isProtected(protectBits, addrReg);
  wire logic goBlk = addrCmdOk && opcode == OP_BLOCK_ERASE && wrOk && !isProtected(protectBits, addrReg);
  wire logic goChip = opOnlyOk && (opcode == OP_CHIP_ERASE_A || opcode == OP_CHIP_ERASE_B) && wrOk
                      && protectBits == 4'h0;
  wire logic goSuspend = opOnlyOk && opcode == OP_SUSPEND && state == FPS_BUSY && !suspended
                         && curOp != FPS_OP_CHIP;
  wire logic goResume = opOnlyOk && opcode == OP_RESUME && suspended && busyIdle;
  wire logic goWren = opOnlyOk && opcode == OP_WRITE_ENABLE && busyIdle;
  wire logic anyStart = goProg || goSect || goHalf || goBlk || goChip;
  wire logic [31:0] startCycles = goProg ? 32'(PROG_CYC) : goSect ? 32'(SECT_CYC) : goHalf ? 32'(HALF_CYC)
                                  : goBlk ? 32'(BLK_CYC) : 32'(CHIP_CYC);
  wire fps_op_e startOp = goProg ? FPS_OP_PROGRAM : goSect ? FPS_OP_SECTOR : goHalf ? FPS_OP_HALF
                          : goBlk ? FPS_OP_BLOCK : FPS_OP_CHIP;
  wire logic cycleEnd = state == FPS_BUSY && remain == 32'd1;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= FPS_IDLE;
      curOp <= FPS_OP_NONE;
      suspended <= 1'b0;
      remain <= 32'd0;
      waitCnt <= 32'd0;
      writeEnableLatch <= 1'b0;
      eraseSuspendedFlag <= 1'b0;
      programSuspendedFlag <= 1'b0;
      targetAddr <= 24'h0;
      flushRun <= 1'b0;
    end else begin
      if (goWren) writeEnableLatch <= 1'b1;
      case (state)
        FPS_IDLE: begin
          if (anyStart) begin
            state <= goProg ? FPS_FLUSH : FPS_BUSY;
            curOp <= startOp;
            remain <= startCycles;
            targetAddr <= addrReg;
            flushRun <= goProg;
          end else if (goResume) begin
            state <= FPS_BUSY;
            suspended <= 1'b0;
            eraseSuspendedFlag <= 1'b0;
            programSuspendedFlag <= 1'b0;
          end
        end
        FPS_FLUSH: begin
          if (flushIdx == 8'hFF && !progWrEn && !flushValid && !flushRun) state <= FPS_BUSY;
          if (flushStep && flushIdx == 8'hFF) flushRun <= 1'b0;
        end
        FPS_BUSY: begin
          if (goSuspend) begin
            state <= FPS_SUSP_WAIT;
            waitCnt <= 32'(SUSP_CYC);
            suspended <= 1'b1;
            if (curOp == FPS_OP_PROGRAM) programSuspendedFlag <= 1'b1;
            else eraseSuspendedFlag <= 1'b1;
          end else if (cycleEnd) begin
            state <= FPS_IDLE;
            curOp <= FPS_OP_NONE;
            writeEnableLatch <= 1'b0;
          end else begin
            remain <= remain - 32'd1;
          end
        end
        FPS_SUSP_WAIT: begin
          if (waitCnt == 32'd1) state <= FPS_IDLE;
          else waitCnt <= waitCnt - 32'd1;
        end
        default: state <= FPS_IDLE;
      endcase
    end
  end
  // Flush walks buffer; only loaded bytes are written
  wire logic [7:0] nextFlushIdx = flushIdx + 8'h01;
  logic [7:0] flushAddrLo;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flushIdx <= 8'h00;
      flushValid <= 1'b0;
      flushAddrLo <= 8'h00;
      progWrEn <= 1'b0;
      progWrAddr <= 24'h0;
      progWrData <= ERASED_BYTE;
    end else begin
      if (progWrEn && progWrReady) progWrEn <= 1'b0;
      if (flushStep) begin
        flushValid <= pageMask[flushIdx];
        flushAddrLo <= flushIdx;
        if (flushIdx != 8'hFF) flushIdx <= nextFlushIdx;
      end else begin
        flushValid <= 1'b0;
      end
      if (flushValid) begin
        progWrEn <= 1'b1;
        progWrAddr <= {targetAddr[23:8], flushAddrLo};
        progWrData <= bufRdData;
      end
      if (state == FPS_IDLE) flushIdx <= 8'h00;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      writeInProgressFlag <= 1'b0;
      activeOp <= 3'b000;
    end else begin
      writeInProgressFlag <= state != FPS_IDLE;
      activeOp <= curOp;
    end
  end
endmodule // fps_flash_seq
`default_nettype wire

// [rtl/fps_page_buf.sv]
`timescale 1ns/1ps
`default_nettype none
module fps_page_buf #(
  parameter int DEPTH = 256
) (
  input wire logic clk,
  input wire logic write_enable_cmd,
  input wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge clk) begin
    if (write_enable_cmd) mem[wrAddr] <= wrData;
    rdData <= mem[rdAddr];
  end
endmodule // fps_page_buf
`default_nettype wire

// [rtl/fps_pkg.sv]
package fps_pkg;
  localparam logic [7:0] OP_QUAD_PROGRAM = 8'h32;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SUSPEND = 8'hB0;
  localparam logic [7:0] OP_RESUME = 8'h30;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int PAGE_BYTES = 256;
  localparam int CLK_MHZ = 250;
  localparam int PROGRAM_TIME_US = 300;
  localparam int SECTOR_ERASE_TIME_US = 40000;
  localparam int HALF_BLOCK_ERASE_TIME_US = 100000;
  localparam int BLOCK_ERASE_TIME_US = 150000;
  localparam int CHIP_ERASE_TIME_US = 1000000;
  localparam int SUSPEND_LATENCY_US = 20;
  localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * CLK_MHZ;
  localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam int HALF_BLOCK_ERASE_CYCLES = HALF_BLOCK_ERASE_TIME_US * CLK_MHZ;
  localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_TIME_US * CLK_MHZ;
  localparam int CHIP_ERASE_CYCLES = CHIP_ERASE_TIME_US * CLK_MHZ;
  localparam int SUSPEND_LATENCY_CYCLES = SUSPEND_LATENCY_US * CLK_MHZ;
  typedef enum logic [2:0] {
    FPS_OP_NONE = 3'b000,
    FPS_OP_PROGRAM = 3'b001,
    FPS_OP_SECTOR = 3'b010,
    FPS_OP_HALF = 3'b011,
    FPS_OP_BLOCK = 3'b100,
    FPS_OP_CHIP = 3'b101
  } fps_op_e;
endpackage
